// ---- shared/svp_pkg.sv ----
// constants, state encoding and widths shared by the servo pulse generator
// How it works
// - frames repeat at 62.5 hertz
// - line high 0.32 to 1.76 ms, low otherwise
// - high time is 160 cycles times setting
// - low time fills frame to 1600000 cycles
// - step left adds 20 below 1100
// - step right subtracts 20 above 200
// - exit stops pulses, releases all four lines
// - four identical servo output channels
// - display shows setting minus 200, over five
// - pulse timing from hardware counters, cycle exact
package svp_pkg;

  // ************************************************************
  // widths
  // ************************************************************
  localparam int SET_W  = 11;
  localparam int CNT_W  = 21;
  localparam int DISP_W = 8;
  localparam int LINES  = 4;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int unsigned CLK_HZ        = 32'h05F5E100;
  // 1 600 000 cycles per frame
  localparam int unsigned FRAME_CYC_DEF = 32'h00186A00;
  // 160 cycles per unit of the position setting
  localparam logic [CNT_W-1:0] HIGH_UNIT = 21'h0000A0;

  // ************************************************************
  // position setting
  // ************************************************************
  localparam logic [SET_W-1:0]  SET_MIN    = 11'h0C8;
  localparam logic [SET_W-1:0]  SET_MAX    = 11'h44C;
  localparam logic [SET_W-1:0]  SET_STEP   = 11'h014;
  localparam logic [SET_W-1:0]  SET_RESET  = 11'h280;
  localparam logic [SET_W-1:0]  DISP_DIV   = 11'h005;
  localparam logic [DISP_W-1:0] DISP_RESET = 8'h58;

  // ************************************************************
  // output sequencer states, gray along released-high-low-high
  // ************************************************************
  typedef enum logic [1:0] {
    SVP_RELEASED = 2'b00,
    SVP_HIGH     = 2'b01,
    SVP_LOW      = 2'b11
  } svp_state_t;

endpackage

// ---- shared/svp_cmd_if.sv ----
// command and position signals between the sequencer and the command control
interface svp_cmd_if;
  import svp_pkg::*;

  logic              step_left;
  logic              step_right;
  logic              exit_req;
  logic              apply;
  logic [SET_W-1:0]  setting;
  logic [DISP_W-1:0] display;
  logic              exit_pend;

  modport ctrl (
    input  step_left,
    input  step_right,
    input  exit_req,
    input  apply,
    output setting,
    output display,
    output exit_pend
  );

  modport user (
    output step_left,
    output step_right,
    output exit_req,
    output apply,
    input  setting,
    input  display,
    input  exit_pend
  );
endinterface

// ---- verilog/svp_frame_timer.sv ----
// frame cycle counter with clear while stopped
module svp_frame_timer #(
  parameter int unsigned FRAME_CYC = svp_pkg::FRAME_CYC_DEF
) (
  input  wire logic                      clock_i,     // system clock
  input  wire logic                      sys_rst_i,   // async reset, active high
  input  wire logic                      run_i,       // count while high, clear while low
  output logic [svp_pkg::CNT_W-1:0]      count_o,     // cycle within frame
  output logic                           frame_end_o  // last cycle of frame
);
  import svp_pkg::*;

  localparam logic [CNT_W-1:0] LAST = CNT_W'(FRAME_CYC - 1);

  logic [CNT_W-1:0] count_reg;

  assign count_o     = count_reg;
  assign frame_end_o = run_i && (count_reg == LAST);

  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      count_reg <= '0;
    else if (!run_i || frame_end_o)
      count_reg <= '0;
    else
      count_reg <= count_reg + 1'b1;
  end
endmodule

// ---- verilog/svp_cmd_ctrl.sv ----
// position setting, pending commands and displayed angle
module svp_cmd_ctrl (
  input  wire logic clock_i,   // system clock
  input  wire logic sys_rst_i, // async reset, active high
  svp_cmd_if.ctrl   cmd        // commands in, setting out
);
  import svp_pkg::*;

  logic              left_pend_reg;
  logic              right_pend_reg;
  logic              exit_pend_reg;
  logic [SET_W-1:0]  setting_reg;
  logic [SET_W-1:0]  setting_next;
  logic [SET_W-1:0]  quot;
  logic [DISP_W-1:0] display_reg;

  assign cmd.setting   = setting_reg;
  assign cmd.display   = display_reg;
  assign cmd.exit_pend = exit_pend_reg;

  // a command arriving on the apply cycle waits for the next frame
  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      left_pend_reg  <= 1'b0;
      right_pend_reg <= 1'b0;
      exit_pend_reg  <= 1'b0;
    end
    else
    begin
      left_pend_reg  <= cmd.step_left  || (left_pend_reg  && !cmd.apply);
      right_pend_reg <= cmd.step_right || (right_pend_reg && !cmd.apply);
      exit_pend_reg  <= cmd.exit_req   || (exit_pend_reg  && !cmd.apply);
    end
  end

  // exit beats left, left beats right
  always_comb
  begin
    setting_next = setting_reg;
    if (exit_pend_reg)
      setting_next = setting_reg;
    else if (left_pend_reg)
    begin
      if (setting_reg < SET_MAX)
        setting_next = setting_reg + SET_STEP;
    end
    else if (right_pend_reg)
    begin
      if (setting_reg > SET_MIN)
        setting_next = setting_reg - SET_STEP;
    end
  end

  assign quot = (setting_next - SET_MIN) / DISP_DIV;

  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      setting_reg <= SET_RESET;
      display_reg <= DISP_RESET;
    end
    else if (cmd.apply && (left_pend_reg || right_pend_reg || exit_pend_reg))
    begin
      setting_reg <= setting_next;
      display_reg <= quot[DISP_W-1:0];
    end
  end
endmodule

// ---- verilog/svp_top.sv ----
// servo pulse generator: frame sequencer driving four servo lines
module svp_top #(
  parameter int unsigned               FRAME_CYC = svp_pkg::FRAME_CYC_DEF,
  parameter logic [svp_pkg::CNT_W-1:0] HIGH_CYC  = svp_pkg::HIGH_UNIT
) (
  input  wire logic                          clock_i,               // system clock
  input  wire logic                          sys_rst_i,             // async reset, active high
  input  wire logic                          step_left_i,           // pulse: raise setting
  input  wire logic                          step_right_i,          // pulse: lower setting
  input  wire logic                          exit_cmd_i,            // pulse: stop and release
  input  wire logic                          start_cmd_i,           // pulse: resume after exit
  output logic [svp_pkg::LINES-1:0]          servo_output_lines_o,  // pulse level per line
  output logic [svp_pkg::LINES-1:0]          servo_oe_n_o,          // low while driving
  output logic [svp_pkg::SET_W-1:0]          pulse_width_setting_o, // current setting
  output logic [svp_pkg::DISP_W-1:0]         display_pos_o,         // displayed angle
  output logic                               active_o               // pulses running
);
  import svp_pkg::*;

  // ************************************************************
  // shared signals
  // ************************************************************
  svp_cmd_if cmd ();

  svp_state_t       state_reg;
  svp_state_t       state_next;
  logic [CNT_W-1:0] count;
  logic             frame_end;
  logic             run;
  logic [CNT_W-1:0] hi_cycles;
  logic [CNT_W-1:0] hi_last;
  logic             line_reg;
  logic             oe_n_reg;
  logic             active_reg;

  assign cmd.step_left  = step_left_i;
  assign cmd.step_right = step_right_i;
  assign cmd.exit_req   = exit_cmd_i;
  assign cmd.apply      = frame_end;

  // ************************************************************
  // submodules
  // ************************************************************
  svp_cmd_ctrl u_ctrl (
    .clock_i   (clock_i),
    .sys_rst_i (sys_rst_i),
    .cmd       (cmd)
  );

  svp_frame_timer #(
    .FRAME_CYC (FRAME_CYC)
  ) u_timer (
    .clock_i     (clock_i),
    .sys_rst_i   (sys_rst_i),
    .run_i       (run),
    .count_o     (count),
    .frame_end_o (frame_end)
  );

  // ************************************************************
  // high time
  // ************************************************************
  // setting only moves at the frame boundary, so no copy is needed
  assign hi_cycles = {{(CNT_W-SET_W){1'b0}}, cmd.setting} * HIGH_CYC;
  assign hi_last   = hi_cycles - 1'b1;
  assign run       = (state_reg != SVP_RELEASED);

  // ************************************************************
  // sequencer
  // ************************************************************
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      SVP_RELEASED:
      begin
        if (start_cmd_i)
          state_next = SVP_HIGH;
      end
      SVP_HIGH:
      begin
        // frame end here only if a shortened frame is not above the high time
        if (frame_end)
          state_next = cmd.exit_pend ? SVP_RELEASED : SVP_HIGH;
        else if (count == hi_last)
          state_next = SVP_LOW;
      end
      SVP_LOW:
      begin
        if (frame_end)
          state_next = cmd.exit_pend ? SVP_RELEASED : SVP_HIGH;
      end
      default:
        state_next = SVP_RELEASED;
    endcase
  end

  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      state_reg <= SVP_LOW;
    else
      state_reg <= state_next;
  end

  // ************************************************************
  // pin drive
  // ************************************************************
  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      line_reg <= 1'b0;
    else
      line_reg <= (state_next == SVP_HIGH);
  end

  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      oe_n_reg   <= 1'b0;
      active_reg <= 1'b1;
    end
    else
    begin
      oe_n_reg   <= (state_next == SVP_RELEASED);
      active_reg <= (state_next != SVP_RELEASED);
    end
  end

  assign servo_output_lines_o  = {LINES{line_reg}};
  assign servo_oe_n_o          = {LINES{oe_n_reg}};
  assign pulse_width_setting_o = cmd.setting;
  assign display_pos_o         = cmd.display;
  assign active_o              = active_reg;

  // ************************************************************
  // checking helpers
  // ************************************************************
  logic             line_q;
  logic             seen_rise_reg;
  logic [CNT_W-1:0] gap_cnt_reg;
  logic [CNT_W-1:0] hi_cnt_reg;
  logic             line_rise;
  logic             line_fall;
  logic [CNT_W-1:0] frame_last;

  assign line_rise  = line_reg && !line_q;
  assign line_fall  = !line_reg && line_q;
  assign frame_last = CNT_W'(FRAME_CYC - 1);

  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      line_q        <= 1'b0;
      seen_rise_reg <= 1'b0;
      gap_cnt_reg   <= '0;
      hi_cnt_reg    <= '0;
    end
    else
    begin
      line_q <= line_reg;
      if (state_reg == SVP_RELEASED)
        seen_rise_reg <= 1'b0;
      else if (line_rise)
        seen_rise_reg <= 1'b1;
      if (line_rise)
        gap_cnt_reg <= '0;
      else
        gap_cnt_reg <= gap_cnt_reg + 1'b1;
      if (line_reg)
        hi_cnt_reg <= hi_cnt_reg + 1'b1;
      else
        hi_cnt_reg <= '0;
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  sequence s_exit_at_frame_end;
    (state_reg != SVP_RELEASED) && frame_end && cmd.exit_pend;
  endsequence

  sequence s_lines_released;
    (servo_oe_n_o == {LINES{1'b1}}) && (servo_output_lines_o == '0) && !active_o;
  endsequence

  sequence s_left_taken;
    frame_end && !cmd.exit_pend && u_ctrl.left_pend_reg;
  endsequence

  sequence s_right_taken;
    frame_end && !cmd.exit_pend && !u_ctrl.left_pend_reg && u_ctrl.right_pend_reg;
  endsequence

  property p_frame_period;
    @(posedge clock_i) disable iff (sys_rst_i)
      (line_rise && seen_rise_reg && (state_reg != SVP_RELEASED))
        |-> (gap_cnt_reg == frame_last);
  endproperty
  a_frame_period: assert property (p_frame_period)
    else $error("frame period differs from the frame cycle count");

  property p_high_len;
    @(posedge clock_i) disable iff (sys_rst_i)
      line_fall |-> (hi_cnt_reg == hi_cycles);
  endproperty
  a_high_len: assert property (p_high_len)
    else $error("high time is not the unit times the setting");

  property p_low_fills_frame;
    @(posedge clock_i) disable iff (sys_rst_i)
      (state_reg == SVP_LOW && !frame_end) |=> (state_reg == SVP_LOW) && !line_reg;
  endproperty
  a_low_fills_frame: assert property (p_low_fills_frame)
    else $error("low time ended before the frame end");

  property p_timer_wrap;
    @(posedge clock_i) disable iff (sys_rst_i)
      frame_end |=> (count == '0);
  endproperty
  a_timer_wrap: assert property (p_timer_wrap)
    else $error("frame counter did not restart after the frame end");

  property p_pending_cleared;
    @(posedge clock_i) disable iff (sys_rst_i)
      (frame_end && !step_left_i) |=> !u_ctrl.left_pend_reg;
  endproperty
  a_pending_cleared: assert property (p_pending_cleared)
    else $error("step left still pending after the frame end");

  property p_step_left;
    @(posedge clock_i) disable iff (sys_rst_i)
      (s_left_taken ##0 (cmd.setting < SET_MAX))
        |=> (cmd.setting == $past(cmd.setting) + SET_STEP);
  endproperty
  a_step_left: assert property (p_step_left)
    else $error("step left did not raise the setting by one step");

  property p_step_right;
    @(posedge clock_i) disable iff (sys_rst_i)
      (s_right_taken ##0 (cmd.setting > SET_MIN))
        |=> (cmd.setting == $past(cmd.setting) - SET_STEP);
  endproperty
  a_step_right: assert property (p_step_right)
    else $error("step right did not lower the setting by one step");

  property p_setting_range;
    @(posedge clock_i) disable iff (sys_rst_i)
      (cmd.setting >= SET_MIN) && (cmd.setting <= SET_MAX);
  endproperty
  a_setting_range: assert property (p_setting_range)
    else $error("setting left its allowed range");

  property p_setting_quiet;
    @(posedge clock_i) disable iff (sys_rst_i)
      !frame_end |=> $stable(cmd.setting);
  endproperty
  a_setting_quiet: assert property (p_setting_quiet)
    else $error("setting changed away from a frame end");

  property p_exit_release;
    @(posedge clock_i) disable iff (sys_rst_i)
      s_exit_at_frame_end |=> s_lines_released ##1 (s_lines_released or active_o);
  endproperty
  a_exit_release: assert property (p_exit_release)
    else $error("exit did not release all lines");

  property p_exit_keeps_setting;
    @(posedge clock_i) disable iff (sys_rst_i)
      s_exit_at_frame_end |=> $stable(cmd.setting);
  endproperty
  a_exit_keeps_setting: assert property (p_exit_keeps_setting)
    else $error("exit changed the setting");

  property p_released_hold;
    @(posedge clock_i) disable iff (sys_rst_i)
      ((state_reg == SVP_RELEASED) && !start_cmd_i) |=> s_lines_released;
  endproperty
  a_released_hold: assert property (p_released_hold)
    else $error("lines driven while released");

  property p_lines_match;
    @(posedge clock_i) disable iff (sys_rst_i)
      ((servo_output_lines_o == '0) || (servo_output_lines_o == {LINES{1'b1}}))
        && ((servo_oe_n_o == '0) || (servo_oe_n_o == {LINES{1'b1}}));
  endproperty
  a_lines_match: assert property (p_lines_match)
    else $error("servo channels disagree");

  property p_display;
    @(posedge clock_i) disable iff (sys_rst_i)
      cmd.display == DISP_W'((cmd.setting - SET_MIN) / DISP_DIV);
  endproperty
  a_display: assert property (p_display)
    else $error("displayed angle does not match the setting");

  property p_start_pulse;
    @(posedge clock_i) disable iff (sys_rst_i)
      ((state_reg == SVP_RELEASED) && start_cmd_i)
        |=> (servo_output_lines_o == {LINES{1'b1}}) && (servo_oe_n_o == '0) && active_o;
  endproperty
  a_start_pulse: assert property (p_start_pulse)
    else $error("start did not begin a pulse at once");

endmodule

// ---- test/svp_servo_model.sv ----
// behavioural hobby servo: measures pulse high time and frame period on its signal pin
module svp_servo_model (
  input  wire logic        clock_i,   // sampling clock
  input  wire logic        pulse_i,   // servo signal pin
  output logic [31:0]      hi_len_o,  // last completed high time, cycles
  output logic [31:0]      per_len_o, // last rise-to-rise period, cycles
  output logic [31:0]      n_pulse_o  // completed pulses
);
  timeunit 1ns;
  timeprecision 1ps;

  logic        prev_reg = 1'b0;
  logic [31:0] hi_reg   = 32'h00000000;
  logic [31:0] per_reg  = 32'h00000000;

  initial
  begin
    hi_len_o  = 32'h00000000;
    per_len_o = 32'h00000000;
    n_pulse_o = 32'h00000000;
  end

  // a servo only listens, so it measures and never drives the pin
  always @(posedge clock_i)
  begin
    prev_reg <= pulse_i;
    if (pulse_i === 1'b1 && prev_reg === 1'b0)
    begin
      hi_reg    <= 32'h00000001;
      per_len_o <= per_reg;
      per_reg   <= 32'h00000001;
    end
    else
    begin
      per_reg <= per_reg + 32'h00000001;
      if (pulse_i === 1'b1)
        hi_reg <= hi_reg + 32'h00000001;
    end
    if (pulse_i === 1'b0 && prev_reg === 1'b1)
    begin
      hi_len_o  <= hi_reg;
      n_pulse_o <= n_pulse_o + 32'h00000001;
    end
  end
endmodule

// ---- test/servo_pulse_generator_tb_top.sv ----
// self-checking bench for the servo pulse generator
module servo_pulse_generator_tb_top;
  import svp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  // ************************************************************
  // set-up
  // ************************************************************
  // short frame and unit keep the run brief; frame still above the longest high time
  localparam int unsigned FRAME_T = 32'h00000960;
  localparam logic [31:0] UNIT    = 32'h00000002;

  logic               clock_i    = 1'b0;
  logic               sys_rst_i  = 1'b1;
  logic               step_left  = 1'b0;
  logic               step_right = 1'b0;
  logic               exit_cmd   = 1'b0;
  logic               start_cmd  = 1'b0;
  logic [LINES-1:0]   lines;
  logic [LINES-1:0]   oe_n;
  logic [SET_W-1:0]   setting;
  logic [DISP_W-1:0]  disp;
  logic               active;
  logic [LINES-1:0]   float_q = '0;
  logic [LINES-1:0]   line_w;
  logic [31:0]        hi_len;
  logic [31:0]        per_len;
  logic [31:0]        n_pulse;
  int                 n_fail    = 0;
  int                 tests_run = 0;

  always #5 clock_i = ~clock_i;

  // a released pin has no pull, so it wanders instead of holding its last level
  assign line_w = (~oe_n & lines) | (oe_n & ~float_q);
  always @(posedge clock_i) float_q <= line_w;

  svp_top #(.FRAME_CYC(FRAME_T), .HIGH_CYC(CNT_W'(UNIT))) dut_u (
    .clock_i               (clock_i),
    .sys_rst_i             (sys_rst_i),
    .step_left_i           (step_left),
    .step_right_i          (step_right),
    .exit_cmd_i            (exit_cmd),
    .start_cmd_i           (start_cmd),
    .servo_output_lines_o  (lines),
    .servo_oe_n_o          (oe_n),
    .pulse_width_setting_o (setting),
    .display_pos_o         (disp),
    .active_o              (active)
  );

  svp_servo_model servo_u (
    .clock_i   (clock_i),
    .pulse_i   (line_w[0]),
    .hi_len_o  (hi_len),
    .per_len_o (per_len),
    .n_pulse_o (n_pulse)
  );

  // ************************************************************
  // helpers
  // ************************************************************
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: %s got %0d expected %0d", $time, msg, got, exp);
    end
  endtask

  task automatic give_up(input string msg);
    n_fail++;
    $display("wrong value at %0t: timed out waiting for %s", $time, msg);
    complete_run();
  endtask

  task automatic send(input logic l, input logic r, input logic x, input logic s);
    @(negedge clock_i);
    step_left  = l;
    step_right = r;
    exit_cmd   = x;
    start_cmd  = s;
    @(negedge clock_i);
    step_left  = 1'b0;
    step_right = 1'b0;
    exit_cmd   = 1'b0;
    start_cmd  = 1'b0;
  endtask

  task automatic wait_pulse();
    logic [31:0] n0;
    n0 = n_pulse;
    for (int i = 0; i < 2 * FRAME_T; i++)
    begin
      @(negedge clock_i);
      if (n_pulse !== n0)
        return;
    end
    give_up("pulse");
  endtask

  task automatic wait_setting(input logic [SET_W-1:0] old);
    for (int i = 0; i < FRAME_T + 4; i++)
    begin
      @(negedge clock_i);
      if (setting !== old)
        return;
    end
    give_up("setting change");
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset();
    repeat (4) @(negedge clock_i);
    check(lines, 32'h0, "lines in reset");
    check(oe_n, 32'h0, "oe_n in reset");
    check(setting, 32'd640, "setting in reset");
    check(disp, 32'd88, "display in reset");
    sys_rst_i = 1'b0;
    repeat (FRAME_T - 1) @(posedge clock_i);
    @(negedge clock_i);
    check(lines, 32'h0, "lines before first rise");
    @(negedge clock_i);
    check(lines, 32'hF, "all four lines rise");
    check(active, 32'h1, "active while running");
    $display("test reset done");
  endtask

  task automatic t_pulse();
    wait_pulse();
    check(hi_len, UNIT * 32'd640, "high time");
    wait_pulse();
    check(hi_len, UNIT * 32'd640, "repeat high time");
    check(per_len, FRAME_T, "frame period");
    $display("test pulse done");
  endtask

  task automatic t_steps();
    send(1'b1, 1'b1, 1'b0, 1'b0);
    wait_setting(11'h280);
    check(setting, 32'd660, "left wins over right");
    check(disp, 32'd92, "display after left");
    wait_pulse();
    wait_pulse();
    check(hi_len, UNIT * 32'd660, "high time after left");
    send(1'b0, 1'b1, 1'b0, 1'b0);
    wait_setting(11'h294);
    check(setting, 32'd640, "step right");
    check(disp, 32'd88, "display after right");
    $display("test steps done");
  endtask

  task automatic t_exit();
    int i;
    send(1'b1, 1'b0, 1'b1, 1'b0);
    for (i = 0; i < FRAME_T + 4 && active !== 1'b0; i++)
      @(negedge clock_i);
    if (active !== 1'b0)
      give_up("release");
    check(oe_n, 32'hF, "lines released");
    check(lines, 32'h0, "released level");
    check(setting, 32'd640, "exit wins over left");
    repeat (20) @(negedge clock_i);
    check(oe_n, 32'hF, "stays released");
    check(active, 32'h0, "no pulses while released");
    send(1'b0, 1'b0, 1'b0, 1'b1);
    check(oe_n, 32'h0, "driven after start");
    check(lines, 32'hF, "high after start");
    repeat (UNIT * 32'd640 - 1) @(negedge clock_i);
    check(lines, 32'hF, "last high cycle");
    @(negedge clock_i);
    check(lines, 32'h0, "low after high time");
    $display("test exit done");
  endtask

  initial
  begin
    t_reset();
    t_pulse();
    t_steps();
    t_exit();
    complete_run();
  end
endmodule
